// ==== logic/hbdi_defs.svh ====
`ifndef HBDI_DEFS_SVH
`define HBDI_DEFS_SVH

// Register select width and reset value of the latched address
`define HBDI_ADDR_W     7
`define HBDI_ADDR_RST   7'h00

// Number of DMA channels and the channel indices
`define HBDI_CHANS      2
`define HBDI_CH_A       0
`define HBDI_CH_B       1

// Receive block sizes, stored as length minus one
`define HBDI_CNT_W      5
`define HBDI_BLK_32     5'h1F
`define HBDI_BLK_16     5'h0F
`define HBDI_BLK_8      5'h07
`define HBDI_BLK_4      5'h03
`define HBDI_CNT_ZERO   5'h00
`define HBDI_CNT_ONE    5'h01

// Block size select codes
`define HBDI_SZ_32      2'h0
`define HBDI_SZ_16      2'h1
`define HBDI_SZ_8       2'h2
`define HBDI_SZ_4       2'h3

`endif

// ==== logic/hbdi_pkg.sv ====
package hbdi_pkg;

    // Access tracker: one strobe makes exactly one access pulse
    typedef enum logic {
        HBDI_ACC_IDLE,
        HBDI_ACC_BUSY
    } hbdi_acc_e;

    // Host port state
    typedef struct packed {
        logic       ale_q;      // Latch strobe seen last cycle
        hbdi_acc_e  acc;
        logic [6:0] addr_r;     // Latched register address
        logic [6:0] reg_addr;
        logic       reg_rd;
        logic       reg_wr;
        logic [1:0] fifo_rd;
        logic [1:0] fifo_wr;
        logic       int_oe;
        logic       ctl_func;   // Function of the mode-dependent pin
        logic       alt_mode;   // Data strobe bus mode in use
    } hbdi_top_s;

    // Receive DMA request state of one channel
    typedef struct packed {
        logic       req;
        logic [4:0] cnt;
    } hbdi_rxd_s;

endpackage

// ==== logic/hbdi_rx_dma.sv ====
`timescale 1ns/1ps
`include "hbdi_defs.svh"

module hbdi_rx_dma
    import hbdi_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       ce_in,
    input  wire logic       need_in,
    input  wire logic [1:0] size_sel_in,
    input  wire logic       rd_pulse_in,
    output logic            req_out
);

    hbdi_rxd_s st_r;
    hbdi_rxd_s st_nxt;

    // Block countdown; the request is held for the whole block
    always_comb begin
        st_nxt = st_r;
        if (!st_r.req) begin
            if (need_in) begin
                st_nxt.req = 1'b1;
                case (size_sel_in)
                    `HBDI_SZ_32: st_nxt.cnt = `HBDI_BLK_32;
                    `HBDI_SZ_16: st_nxt.cnt = `HBDI_BLK_16;
                    `HBDI_SZ_8:  st_nxt.cnt = `HBDI_BLK_8;
                    default:     st_nxt.cnt = `HBDI_BLK_4;
                endcase
            end
        end else if (rd_pulse_in) begin
            // Last read drops the request on the next edge
            if (st_r.cnt == `HBDI_CNT_ZERO) begin
                st_nxt.req = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - `HBDI_CNT_ONE;
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_r <= '{req: 1'b0, cnt: `HBDI_CNT_ZERO};
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign req_out = st_r.req;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    req_drop_a: assert property (ce_in && st_r.req && rd_pulse_in
        && st_r.cnt == `HBDI_CNT_ZERO |=> !req_out)
        else $error("request not dropped after last read");
    req_hold_a: assert property (ce_in && st_r.req
        && st_r.cnt != `HBDI_CNT_ZERO |=> req_out)
        else $error("request dropped before block end");
    req_rise_a: assert property (ce_in && !st_r.req && need_in
        && size_sel_in == `HBDI_SZ_4 |=> req_out
        && st_r.cnt == `HBDI_BLK_4)
        else $error("request or count wrong at block start");
    blk_done_c: cover property (st_r.req && rd_pulse_in
        && st_r.cnt == `HBDI_CNT_ZERO);

endmodule // hbdi_rx_dma

// ==== logic/hbdi_top.sv ====
// How it works
// - Latch strobe high marks an address phase
// - Address captured on latch strobe falling edge
// - Secondary mode pin picks control pin function
// - Seven address bits select one register
// - Interrupt output active while interrupt pending
// - Interrupt output only pulls low or floats
// - Acknowledged strobes access the channel FIFO top
// - Active acknowledge overrides the address inputs
// - Primary mode pin selects bus protocol
// - Receive request held per block, drops after last
`timescale 1ns/1ps
`include "hbdi_defs.svh"

module hbdi_top
    import hbdi_pkg::*;
(
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_B_IN,
    input  wire logic       CE_IN,
    input  wire logic       PRIMARY_MODE_IN,
    input  wire logic       ALE_SEC_MODE_IN,
    input  wire logic [6:0] ADDR_IN,
    input  wire logic       CS_N_IN,
    input  wire logic       RD_DS_N_IN,
    input  wire logic       WR_N_RW_IN,
    input  wire logic [1:0] DMA_ACK_N_IN,
    input  wire logic       IRQ_PENDING_IN,
    input  wire logic [1:0] RX_NEED_IN,
    input  wire logic [1:0] RX_BLK_SEL_IN,
    output logic [6:0]      REG_ADDR_OUT,
    output logic            REG_RD_OUT,
    output logic            REG_WR_OUT,
    output logic [1:0]      FIFO_RD_OUT,
    output logic [1:0]      FIFO_WR_OUT,
    output logic [1:0]      RX_DMA_REQ_OUT,
    output logic            INT_N_OUT,
    output logic            INT_OE_OUT,
    output logic            CTL_FUNC_OUT,
    output logic            ALT_MODE_OUT
);

    localparam hbdi_top_s TOP_RST = '{
        ale_q:    1'b1,
        acc:      HBDI_ACC_IDLE,
        addr_r:   `HBDI_ADDR_RST,
        reg_addr: `HBDI_ADDR_RST,
        reg_rd:   1'b0,
        reg_wr:   1'b0,
        fifo_rd:  2'h0,
        fifo_wr:  2'h0,
        int_oe:   1'b0,
        ctl_func: 1'b0,
        alt_mode: 1'b0
    };

    hbdi_top_s  st_r;
    hbdi_top_s  st_nxt;
    logic       alt_mode;
    logic [1:0] dack_act;
    logic       sel;
    logic       strobe;
    logic       is_rd;
    logic       ale_fall;
    logic       mux_phase;

    // Pin decode; the mode pin is a strap and is taken as static
    always_comb begin
        alt_mode  = PRIMARY_MODE_IN;
        dack_act  = ~DMA_ACK_N_IN;
        sel       = ~CS_N_IN | (|dack_act);
        strobe    = sel & (alt_mode ? ~RD_DS_N_IN
                                    : (~RD_DS_N_IN | ~WR_N_RW_IN));
        is_rd     = alt_mode ? WR_N_RW_IN : ~RD_DS_N_IN;
        ale_fall  = !alt_mode && st_r.ale_q && !ALE_SEC_MODE_IN;
        // Latch strobe low during a strobe means a multiplexed bus
        mux_phase = !alt_mode && !ALE_SEC_MODE_IN;
    end

    // Next state: address latch, access pulses, pin functions
    always_comb begin
        st_nxt         = st_r;
        st_nxt.ale_q   = ALE_SEC_MODE_IN;
        st_nxt.reg_rd  = 1'b0;
        st_nxt.reg_wr  = 1'b0;
        st_nxt.fifo_rd = 2'h0;
        st_nxt.fifo_wr = 2'h0;
        // High phase only selects; the address is taken at the fall
        if (ale_fall) begin
            st_nxt.addr_r = ADDR_IN;
        end
        case (st_r.acc)
            HBDI_ACC_IDLE: begin
                if (strobe) begin
                    st_nxt.acc = HBDI_ACC_BUSY;
                    // Channel A wins if both acknowledges are low
                    if (dack_act[`HBDI_CH_A]) begin
                        st_nxt.fifo_rd[`HBDI_CH_A] = is_rd;
                        st_nxt.fifo_wr[`HBDI_CH_A] = !is_rd;
                    end else if (dack_act[`HBDI_CH_B]) begin
                        st_nxt.fifo_rd[`HBDI_CH_B] = is_rd;
                        st_nxt.fifo_wr[`HBDI_CH_B] = !is_rd;
                    end else begin
                        st_nxt.reg_addr = mux_phase ? st_nxt.addr_r
                                                    : ADDR_IN;
                        st_nxt.reg_rd   = is_rd;
                        st_nxt.reg_wr   = !is_rd;
                    end
                end
            end
            HBDI_ACC_BUSY: begin
                // Wait for the strobe to end so one access is one pulse
                if (!strobe) begin
                    st_nxt.acc = HBDI_ACC_IDLE;
                end
            end
            default: begin
                st_nxt.acc = HBDI_ACC_IDLE;
            end
        endcase
        st_nxt.int_oe  = IRQ_PENDING_IN;
        // Shared pin is the mode level only in the alternate bus mode
        st_nxt.ctl_func = alt_mode && ALE_SEC_MODE_IN;
        st_nxt.alt_mode = alt_mode;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            st_r <= TOP_RST;
        end else if (CE_IN) begin
            st_r <= st_nxt;
        end
    end

    // Receive DMA request, one tracker per channel
    genvar ch;
    generate
        for (ch = 0; ch < `HBDI_CHANS; ch++) begin : g_rxd
            hbdi_rx_dma u_rxd (
                .clk_in      (SYS_CLK_IN),
                .rst_b_in    (RST_B_IN),
                .ce_in       (CE_IN),
                .need_in     (RX_NEED_IN[ch]),
                .size_sel_in (RX_BLK_SEL_IN),
                .rd_pulse_in (st_r.fifo_rd[ch]),
                .req_out     (RX_DMA_REQ_OUT[ch])
            );
        end
    endgenerate

    // Outputs straight from the state register, all but the constant interrupt level
    assign REG_ADDR_OUT  = st_r.reg_addr;
    assign REG_RD_OUT    = st_r.reg_rd;
    assign REG_WR_OUT    = st_r.reg_wr;
    assign FIFO_RD_OUT   = st_r.fifo_rd;
    assign FIFO_WR_OUT   = st_r.fifo_wr;
    // Open drain: the level is always low, only the enable moves
    assign INT_N_OUT     = 1'b0;
    assign INT_OE_OUT    = st_r.int_oe;
    assign CTL_FUNC_OUT  = st_r.ctl_func;
    assign ALT_MODE_OUT  = st_r.alt_mode;

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    addr_latch_a: assert property (CE_IN && ale_fall
        |=> st_r.addr_r == $past(ADDR_IN))
        else $error("address not captured at latch fall");
    addr_hold_a: assert property (CE_IN && !ale_fall
        |=> $stable(st_r.addr_r))
        else $error("latched address changed without latch fall");
    mux_addr_a: assert property (CE_IN && ale_fall ##1 CE_IN
        && st_r.acc == HBDI_ACC_IDLE && strobe && !(|dack_act)
        && !ALE_SEC_MODE_IN |=> REG_ADDR_OUT == $past(ADDR_IN, 2))
        else $error("multiplexed access used wrong address");
    demux_addr_a: assert property (CE_IN && !alt_mode
        && ALE_SEC_MODE_IN
        && st_r.acc == HBDI_ACC_IDLE && strobe && !(|dack_act)
        |=> REG_ADDR_OUT == $past(ADDR_IN) && (REG_RD_OUT ^ REG_WR_OUT))
        else $error("register access lost its address");
    dma_route_a: assert property (CE_IN && st_r.acc == HBDI_ACC_IDLE
        && strobe && dack_act[`HBDI_CH_A] |=> !REG_RD_OUT && !REG_WR_OUT
        && (FIFO_RD_OUT[`HBDI_CH_A] ^ FIFO_WR_OUT[`HBDI_CH_A]))
        else $error("acknowledged access not sent to FIFO");
    dma_dir_a: assert property (CE_IN && st_r.acc == HBDI_ACC_IDLE
        && strobe && dack_act == 2'h2 && is_rd
        |=> FIFO_RD_OUT == 2'h2 && FIFO_WR_OUT == 2'h0)
        else $error("DMA read reached wrong FIFO");
    // A frozen enable may stretch the pulse, so only a live cycle ends it
    alt_read_a: assert property (CE_IN && alt_mode && !CS_N_IN
        && !(|dack_act) && !RD_DS_N_IN && WR_N_RW_IN
        && st_r.acc == HBDI_ACC_IDLE
        |=> REG_RD_OUT ##1 (!REG_RD_OUT || !$past(CE_IN)))
        else $error("alternate mode read not decoded");
    int_follow_a: assert property (CE_IN |=>
        INT_OE_OUT == $past(IRQ_PENDING_IN))
        else $error("interrupt enable does not track pending");
    int_low_a: assert property (INT_N_OUT == 1'b0)
        else $error("interrupt pin driven high");
    ctl_func_a: assert property (CE_IN |=>
        CTL_FUNC_OUT == ($past(alt_mode) && $past(ALE_SEC_MODE_IN)))
        else $error("control pin function wrong");
    // One access pulse at a time, whatever the strobes and acks do
    pulse_one_a: assert property ($onehot0({REG_RD_OUT, REG_WR_OUT,
        FIFO_RD_OUT, FIFO_WR_OUT}))
        else $error("more than one access pulse");
    busy_refuse_a: assert property (CE_IN
        && st_r.acc == HBDI_ACC_BUSY |=> !REG_RD_OUT && !REG_WR_OUT
        && FIFO_RD_OUT == 2'h0 && FIFO_WR_OUT == 2'h0)
        else $error("held strobe made a second access");
    // Low enable must freeze every piece of port state
    ce_freeze_a: assert property (!CE_IN |=> $stable(st_r))
        else $error("state moved while enable was low");

    reg_rd_c: cover property (REG_RD_OUT);
    alt_wr_c: cover property (alt_mode && REG_WR_OUT);
    reg_wr_mux_c: cover property (ale_fall ##[1:4] REG_WR_OUT);
    fifo_wr_c: cover property (FIFO_WR_OUT[`HBDI_CH_B]);

endmodule // hbdi_top

// ==== test/hbdi_host_model.sv ====
`timescale 1ns/1ps

module hbdi_host_model (
    input  wire logic       clk_in,
    input  wire logic       mode_in,
    output logic            ale_out,
    output logic [6:0]      addr_out,
    output logic            cs_n_out,
    output logic            rd_ds_n_out,
    output logic            wr_n_rw_out,
    output logic [1:0]      ack_n_out
);
    // Idle bus: nothing selected, latch strobe parked high
    initial begin
        ale_out     = 1'b1;
        addr_out    = 7'h00;
        cs_n_out    = 1'b1;
        rd_ds_n_out = 1'b1;
        wr_n_rw_out = 1'b1;
        ack_n_out   = 2'b11;
    end

    // A demultiplexed host keeps the latch strobe high
    task automatic set_ale(input logic v);
        @(posedge clk_in);
        ale_out <= v;
    endtask

    // One access; strobe held through the edge that takes it
    task automatic access(input logic [1:0] k, input logic rd,
                          input logic [6:0] a, input logic mux);
        @(posedge clk_in);
        if (mux) begin
            ale_out  <= 1'b1;
            addr_out <= a;
            @(posedge clk_in);
            ale_out  <= 1'b0;
            @(posedge clk_in);
        end
        // Junk on the address lines when they must not matter
        addr_out    <= (mux || k != 2'b11) ? ~a : a;
        ack_n_out   <= k;
        cs_n_out    <= (k != 2'b11);
        rd_ds_n_out <= !(rd || mode_in);
        wr_n_rw_out <= rd;
        @(posedge clk_in);
        @(negedge clk_in);
    endtask

    // Release select, data strobes and acks, latch strobe left as is; address lines flip so stale values never help
    task automatic release_bus();
        @(posedge clk_in);
        ack_n_out   <= 2'b11;
        cs_n_out    <= 1'b1;
        rd_ds_n_out <= 1'b1;
        wr_n_rw_out <= 1'b1;
        addr_out    <= ~addr_out;
        @(negedge clk_in);
    endtask
endmodule // hbdi_host_model

// ==== test/tb.sv ====
`timescale 1ns/1ps

module tb;
    import hbdi_pkg::*;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode = 1'b0;
    logic        irq = 1'b0;
    logic [1:0]  need = 2'b00;
    logic [1:0]  blk = 2'h0;
    logic        ale, cs_n, rd_n, wr_n;
    logic [6:0]  addr, reg_addr;
    logic [1:0]  ack_n, fifo_rd, fifo_wr, req;
    logic        reg_rd, reg_wr, int_n, int_oe, ctl, alt;
    logic        irq_d = 1'b0, ctl_d = 1'b0, alt_d = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] seed = 32'h0000_d22d;
    logic [31:0] r;
    logic [1:0]  kk[3] = '{2'b10, 2'b01, 2'b00};
    int          rem[2] = '{0, 0};
    int          n_errors = 0, n_checks = 0, cycles = 0;

    always #5 clk = ~clk;

    hbdi_host_model host (
        .clk_in      (clk),
        .mode_in     (mode),
        .ale_out     (ale),
        .addr_out    (addr),
        .cs_n_out    (cs_n),
        .rd_ds_n_out (rd_n),
        .wr_n_rw_out (wr_n),
        .ack_n_out   (ack_n)
    );

    hbdi_top uut (
        .SYS_CLK_IN      (clk),
        .RST_B_IN        (rst_b),
        .CE_IN           (ce),
        .PRIMARY_MODE_IN (mode),
        .ALE_SEC_MODE_IN (ale),
        .ADDR_IN         (addr),
        .CS_N_IN         (cs_n),
        .RD_DS_N_IN      (rd_n),
        .WR_N_RW_IN      (wr_n),
        .DMA_ACK_N_IN    (ack_n),
        .IRQ_PENDING_IN  (irq),
        .RX_NEED_IN      (need),
        .RX_BLK_SEL_IN   (blk),
        .REG_ADDR_OUT    (reg_addr),
        .REG_RD_OUT      (reg_rd),
        .REG_WR_OUT      (reg_wr),
        .FIFO_RD_OUT     (fifo_rd),
        .FIFO_WR_OUT     (fifo_wr),
        .RX_DMA_REQ_OUT  (req),
        .INT_N_OUT       (int_n),
        .INT_OE_OUT      (int_oe),
        .CTL_FUNC_OUT    (ctl),
        .ALT_MODE_OUT    (alt)
    );

    // Fixed-seed xorshift keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Reference pipeline of the level outputs, plus random interrupts
    always @(posedge clk) begin
        // Low enable holds the reference just as it holds the port
        irq_d  <= rst_b & (ce ? irq : irq_d);
        alt_d  <= rst_b & (ce ? mode : alt_d);
        ctl_d  <= rst_b & (ce ? mode & ale : ctl_d);
        irq    <= ^rnd();
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            finish_test();
        end
    end

    // Level outputs are settled at the falling edge
    always @(negedge clk) begin
        chk({7'b0, int_oe}, {7'b0, irq_d});
        chk({7'b0, int_n}, 8'h00);
        chk({6'b0, ctl, alt}, {6'b0, ctl_d, alt_d});
    end

    // One access checked against the model; k is the acknowledge pair
    task automatic acc(input logic [1:0] k, input logic rd,
                       input logic [6:0] a, input logic mux,
                       input logic [6:0] ea);
        int ch;
        logic [5:0] ep;
        ch = !k[0] ? 0 : (!k[1] ? 1 : 2);
        ep = 6'h00;
        if (ch == 2) ep[rd] = 1'b1;
        else begin
            ep[(rd ? 4 : 2) + ch] = 1'b1;
            if (rd && rem[ch] > 0) rem[ch]--;
        end
        host.access(k, rd, a, mux);
        chk({2'b0, fifo_rd, fifo_wr, reg_rd, reg_wr}, {2'b0, ep});
        if (ch == 2) chk({1'b0, reg_addr}, {1'b0, ea});
        host.release_bus();
        chk({2'b0, fifo_rd, fifo_wr, reg_rd, reg_wr}, 8'h00);
        chk({6'b0, req}, {6'b0, rem[1] > 0, rem[0] > 0});
    endtask

    // Raise the receive need for one cycle and expect the request
    task automatic arm(input int ch, input logic [1:0] sz);
        @(posedge clk);
        blk      <= sz;
        need[ch] <= 1'b1;
        @(posedge clk);
        need[ch] <= 1'b0;
        @(negedge clk);
        rem[ch] = 32 >> sz;
        chk({7'b0, req[ch]}, 8'h01);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // Live address: mode 0, then mode 1 at both secondary levels
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode <= (m != 0);
            host.set_ale(m != 1);
            for (int i = 0; i < 6; i++) begin
                r = rnd();
                acc(2'b11, r[7], r[6:0], 1'b0, r[6:0]);
            end
        end
        // Latched address, then reuse of it with junk on the lines
        @(posedge clk);
        mode <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            acc(2'b11, r[7], r[6:0], 1'b1, r[6:0]);
            acc(2'b11, r[8], r[14:8], 1'b0, r[6:0]);
        end
        // Every block size, plus one surplus read after the drop
        for (int s = 0; s < 4; s++) begin
            arm(s % 2, s[1:0]);
            for (int i = 0; i <= (32 >> s); i++) begin
                r = rnd();
                acc(s[0] ? 2'b01 : 2'b10, 1'b1, r[6:0], 1'b0, 7'h00);
            end
        end
        // Acknowledged writes and reads; both low means channel A
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            acc(kk[i % 3], r[7], r[6:0], 1'b0, 7'h00);
        end
        // Frozen enable: the mode pin moves but no output may follow
        @(posedge clk);
        ce   <= 1'b0;
        mode <= 1'b1;
        repeat (5) @(posedge clk);
        mode <= 1'b0;
        @(posedge clk);
        ce   <= 1'b1;
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule // tb
